// ===== np_credit_and_rx_msg_status_bench.sv
`default_nettype none
`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module np_credit_and_rx_msg_status_bench import npc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic nrst, link_up, rx_msg_valid, rx_msg_ready, msg_received, irq, may_issue, issue_np;
    logic [7:0] np_hdr_credits, s_axi_awaddr, s_axi_araddr, got_gap, msg_received_data;
    logic [11:0] np_pld_credits;
    logic [4:0] rx_msg_type, msg_received_type, got_type;
    logic [31:0] rx_msg_params, s_axi_wdata, s_axi_rdata, got_bytes, rd;
    logic [1:0] np_header_credit_avail, np_payload_credit_avail, s_axi_bresp, s_axi_rresp, rs;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int num_errors = 0;
    int cmp_count = 0;

    always #50 ref_clk = ~ref_clk;

    // Lookup gives lengths 1 to 4 by type modulo four
    npc_status #(.MSG_LEN_LUT({8{8'he4}})) dut (.ref_clk, .nrst, .link_up, .np_hdr_credits,
        .np_pld_credits, .rx_msg_valid, .rx_msg_ready, .rx_msg_type, .rx_msg_params,
        .np_header_credit_avail, .np_payload_credit_avail, .msg_received, .msg_received_type,
        .msg_received_data, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    npc_user_model umodel (.ref_clk, .nrst, .msg_received, .msg_received_type,
        .msg_received_data, .np_header_credit_avail, .np_payload_credit_avail, .issue_np,
        .may_issue, .got_type, .got_bytes, .got_gap);

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    task automatic timeout();
        num_errors++;
        $display("Wait limit reached at %0t", $time);
        print_verdict();
    endtask : timeout

    function automatic logic [1:0] exp_code(input logic [11:0] n);
        return (n > 12'h2) ? 2'h3 : n[1:0];
    endfunction : exp_code

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) timeout();
        `CHK(s_axi_bresp, NPC_RESP_OKAY);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 40) timeout();
    endtask : axi_rd

    // Offer one message, count strobe cycles, then compare what the user side saw
    task automatic send_msg(input logic [4:0] t, input logic [31:0] p, input int len);
        int n;
        int k;
        logic [31:0] m;
        @(posedge ref_clk);
        rx_msg_valid <= 1'b1;
        rx_msg_type <= t;
        rx_msg_params <= p;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (rx_msg_ready) break;
        end
        rx_msg_valid <= 1'b0;
        rx_msg_type <= ~t; // Released lines must not keep the old value
        rx_msg_params <= ~p;
        if (n == 20) timeout();
        @(negedge ref_clk);
        for (k = 0; k < 8 && msg_received; k++) @(negedge ref_clk);
        `CHK(k, len);
        `CHK({msg_received_type, msg_received_data}, 13'h0);
        if (len > 0) begin
            m = (len == 4) ? 32'hffff_ffff : (32'h1 << (8 * len)) - 32'h1;
            `CHK(got_type, t);
            `CHK(got_bytes, p & m);
            `CHK(got_gap != 8'h0, 1'b1);
        end
    endtask : send_msg

    task automatic t_regs();
        axi_rd(NPC_CTRL_OFS, rd, rs);
        `CHK(rd, NPC_CTRL_RST);
        axi_rd(NPC_INT_MASK_OFS, rd, rs);
        `CHK(rd, 32'h0);
        axi_rd(NPC_MSG_COUNT_OFS, rd, rs);
        `CHK(rd, 32'h0);
        axi_rd(8'h18, rd, rs);
        `CHK({rs, rd}, {NPC_RESP_SLVERR, 32'h0});
    endtask : t_regs

    // Counts are driven anew on each of eight cycles; indicators follow exactly two edges behind
    task automatic t_credits();
        logic [7:0] hv [8] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'hff, 8'h04, 8'h02};
        logic [11:0] pv [8] = '{12'h3, 12'h0, 12'hfff, 12'h1, 12'h2, 12'h0, 12'h7, 12'h3};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            if (i < 8) np_hdr_credits <= hv[i];
            if (i < 8) np_pld_credits <= pv[i];
            @(negedge ref_clk);
            if (i >= 2) `CHK(np_header_credit_avail, exp_code({4'h0, hv[i-2]}));
            if (i >= 2) `CHK(np_payload_credit_avail, exp_code(pv[i-2]));
        end
        @(posedge ref_clk);
        link_up <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK({np_header_credit_avail, np_payload_credit_avail}, 4'h0);
        axi_rd(NPC_INT_STATUS_OFS, rd, rs);
        `CHK(rd[3:1], 3'h7);
        `CHK(irq, 1'b0);
        link_up <= 1'b1;
        np_hdr_credits <= 8'h05;
        np_pld_credits <= 12'h001;
        axi_rd(NPC_INT_STATUS_OFS, rd, rs);
        `CHK(rd, 32'h0);
        axi_rd(NPC_STATUS_OFS, rd, rs);
        `CHK(rd, 32'h0000_0017);
        @(posedge ref_clk);
        issue_np <= 1'b1;
        @(posedge ref_clk);
        issue_np <= 1'b0;
        @(negedge ref_clk);
        `CHK(may_issue, 1'b0);
    endtask : t_credits

    // Every type, back to back
    task automatic t_msgs();
        for (int t = 0; t < 32; t++) begin
            send_msg(5'(t), {8'(t + 3), 8'(t * 5), 8'ha5 ^ 8'(t), 8'(t + 64)}, t % 4 + 1);
        end
    endtask : t_msgs

    task automatic t_irq();
        axi_rd(NPC_INT_STATUS_OFS, rd, rs);
        axi_wr(NPC_INT_MASK_OFS, 32'h1);
        `CHK(irq, 1'b0);
        send_msg(5'h02, 32'hc3b2_a190, 3);
        `CHK(irq, 1'b1);
        axi_rd(NPC_INT_STATUS_OFS, rd, rs);
        `CHK(rd, 32'h1);
        @(negedge ref_clk);
        `CHK(irq, 1'b0);
        axi_rd(NPC_MSG_COUNT_OFS, rd, rs);
        `CHK(rd, 32'h21);
        axi_rd(NPC_LAST_MSG_OFS, rd, rs);
        `CHK(rd, 32'h2);
        axi_wr(NPC_INT_MASK_OFS, 32'h0);
    endtask : t_irq

    // Reporting switched off: messages are taken and dropped
    task automatic t_disabled();
        axi_wr(NPC_CTRL_OFS, 32'h0);
        @(negedge ref_clk);
        `CHK(rx_msg_ready, 1'b1);
        send_msg(5'h01, 32'h1234_5678, 0);
        axi_rd(NPC_MSG_COUNT_OFS, rd, rs);
        `CHK(rd, 32'h21);
        axi_wr(NPC_CTRL_OFS, 32'h1);
    endtask : t_disabled

    initial begin
        nrst = 1'b0;
        link_up = 1'b1;
        np_hdr_credits = 8'h05;
        np_pld_credits = 12'h009;
        rx_msg_valid = 1'b0;
        rx_msg_type = 5'h0;
        rx_msg_params = 32'h0;
        issue_np = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_wstrb = 4'hf;
        repeat (19) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK({np_header_credit_avail, np_payload_credit_avail, msg_received, irq}, 6'h0);
        @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_credits();
        t_msgs();
        t_irq();
        t_disabled();
        print_verdict();
    end
endmodule : np_credit_and_rx_msg_status_bench
`default_nettype wire

// ===== npc_msg_if.sv
`default_nettype none
interface npc_msg_if;
    logic in_valid;
    logic in_ready;
    logic [4:0] in_type;
    logic [31:0] in_params;
    logic enable;
    logic out_strobe;
    logic [4:0] out_type;
    logic [7:0] out_data;
    logic done;
    logic busy;

    modport ctl (
        output in_valid, in_type, in_params, enable,
        input in_ready, out_strobe, out_type, out_data, done, busy
    );
    modport ser (
        input in_valid, in_type, in_params, enable,
        output in_ready, out_strobe, out_type, out_data, done, busy
    );
endinterface : npc_msg_if
`default_nettype wire

// ===== npc_msg_ser.sv
`default_nettype none
module npc_msg_ser
    import npc_pkg::*;
#(
    parameter logic [63:0] LEN_LUT = NPC_LEN_LUT_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic nrst,
    npc_msg_if.ser mi
);
    npc_ser_state_type state_reg, state_next;
    logic [1:0] idx_reg;
    logic [1:0] last_reg;
    logic [4:0] type_reg;
    logic [7:0] data_reg;
    logic [23:0] rest_reg;
    logic [5:0] lut_pos;
    logic take;
    logic at_last;

    // Handshake and lookup decode
    assign mi.in_ready = (state_reg == NPC_IDLE) && mi.enable;
    assign take = mi.in_valid && mi.in_ready;
    assign lut_pos = {mi.in_type, 1'b0};
    assign at_last = (idx_reg == last_reg);
    assign mi.out_strobe = (state_reg == NPC_SEND);
    assign mi.out_type = type_reg;
    assign mi.out_data = data_reg;
    assign mi.done = mi.out_strobe && at_last;
    assign mi.busy = (state_reg != NPC_IDLE);

    // Sequencer; the gap state forces the strobe low between messages
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NPC_IDLE: if (take) state_next = NPC_SEND;
            NPC_SEND: if (at_last) state_next = NPC_GAP;
            NPC_GAP: state_next = NPC_IDLE;
            default: state_next = NPC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) state_reg <= NPC_IDLE;
        else state_reg <= state_next;
    end

    // Byte shifter: byte 0 goes out first, type and data cleared after the last
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            idx_reg <= 2'h0;
            last_reg <= 2'h0;
            type_reg <= 5'h00;
            data_reg <= 8'h00;
            rest_reg <= 24'h00_0000;
        end else if (take) begin
            idx_reg <= 2'h0;
            last_reg <= LEN_LUT[lut_pos +: 2];
            type_reg <= mi.in_type;
            data_reg <= mi.in_params[7:0];
            rest_reg <= mi.in_params[31:8];
        end else if (mi.out_strobe) begin
            if (at_last) begin
                type_reg <= 5'h00;
                data_reg <= 8'h00;
            end else begin
                idx_reg <= idx_reg + 2'h1;
                data_reg <= rest_reg[7:0];
                rest_reg <= {8'h00, rest_reg[23:8]};
            end
        end
    end

    property p_gap;
        @(posedge ref_clk) disable iff (!nrst)
        mi.done |=> !mi.out_strobe ##1 !mi.out_strobe;
    endproperty
    a_gap: assert property (p_gap) else $error("no gap after message");

    property p_data_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        !mi.out_strobe |-> (mi.out_data == 8'h00) && (mi.out_type == 5'h00);
    endproperty
    a_data_quiet: assert property (p_data_quiet) else $error("data outside strobe");

    property p_type_stable;
        @(posedge ref_clk) disable iff (!nrst)
        mi.out_strobe && $past(mi.out_strobe) |-> $stable(mi.out_type);
    endproperty
    a_type_stable: assert property (p_type_stable) else $error("type moved in msg");

    property p_len;
        @(posedge ref_clk) disable iff (!nrst)
        take ##1 (LEN_LUT[{type_reg, 1'b0} +: 2] == 2'h0) |-> mi.done;
    endproperty
    a_len: assert property (p_len) else $error("one-cycle message too long");

    property p_enable;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(mi.out_strobe) |-> $past(mi.enable);
    endproperty
    a_enable: assert property (p_enable) else $error("message while disabled");
endmodule : npc_msg_ser
`default_nettype wire

// ===== npc_pkg.sv
`default_nettype none
package npc_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] NPC_CTRL_OFS = 8'h00;
    localparam logic [7:0] NPC_STATUS_OFS = 8'h04;
    localparam logic [7:0] NPC_INT_STATUS_OFS = 8'h08;
    localparam logic [7:0] NPC_INT_MASK_OFS = 8'h0c;
    localparam logic [7:0] NPC_MSG_COUNT_OFS = 8'h10;
    localparam logic [7:0] NPC_LAST_MSG_OFS = 8'h14;

    // Field positions
    localparam int NPC_CTRL_MSG_EN_BIT = 0;
    localparam int NPC_ST_NPH_LSB = 0;
    localparam int NPC_ST_NPD_LSB = 2;
    localparam int NPC_ST_LINK_BIT = 4;
    localparam int NPC_ST_BUSY_BIT = 5;
    localparam int NPC_EV_MSG_BIT = 0;
    localparam int NPC_EV_NPH_ZERO_BIT = 1;
    localparam int NPC_EV_NPD_ZERO_BIT = 2;
    localparam int NPC_EV_LINK_DOWN_BIT = 3;
    localparam int NPC_EV_W = 4;

    // Values after reset
    localparam logic [31:0] NPC_CTRL_RST = 32'h0000_0001;
    localparam logic [NPC_EV_W-1:0] NPC_INT_MASK_RST = 4'h0;
    localparam logic [15:0] NPC_MSG_COUNT_RST = 16'h0000;

    // Credit indicator codes
    localparam logic [1:0] NPC_CRED_NONE = 2'h0;
    localparam logic [1:0] NPC_CRED_MANY = 2'h3;
    localparam logic [11:0] NPC_CRED_SAT = 12'h003;

    // AXI responses
    localparam logic [1:0] NPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] NPC_RESP_SLVERR = 2'h2;

    // Message lookup: per type, cycles of strobe minus one (2 bits, 32 types)
    localparam logic [63:0] NPC_LEN_LUT_DEFAULT = {16{4'h4}};

    typedef enum logic [1:0] {
        NPC_IDLE = 2'b00,
        NPC_SEND = 2'b01,
        NPC_GAP = 2'b10
    } npc_ser_state_type;

    // Saturating 2-bit credit code
    function automatic logic [1:0] npc_cred_enc(input logic [11:0] n);
        npc_cred_enc = (n >= NPC_CRED_SAT) ? NPC_CRED_MANY : n[1:0];
    endfunction : npc_cred_enc
endpackage : npc_pkg
`default_nettype wire

// ===== npc_status.sv
// Added by the designer: the AXI4-Lite register port and the register offsets.
`default_nettype none
module npc_status
    import npc_pkg::*;
#(
    parameter logic RX_MSG_IF_EN = 1'b1,
    parameter logic [63:0] MSG_LEN_LUT = NPC_LEN_LUT_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic link_up,
    input wire logic [7:0] np_hdr_credits,
    input wire logic [11:0] np_pld_credits,
    input wire logic rx_msg_valid,
    output logic rx_msg_ready,
    input wire logic [4:0] rx_msg_type,
    input wire logic [31:0] rx_msg_params,
    output logic [1:0] np_header_credit_avail,
    output logic [1:0] np_payload_credit_avail,
    output logic msg_received,
    output logic [4:0] msg_received_type,
    output logic [7:0] msg_received_data,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    npc_msg_if mi ();

    logic [31:0] ctrl_reg;
    logic [NPC_EV_W-1:0] int_status_reg, int_status_next;
    logic [NPC_EV_W-1:0] int_mask_reg;
    logic [15:0] msg_count_reg;
    logic [4:0] last_type_reg;
    logic [1:0] nph_s1_reg, npd_s1_reg;
    logic [1:0] nph_reg, npd_reg;
    logic link_up_d_reg;
    logic aw_held_reg, w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    logic msg_en;
    logic do_write, rd_take;
    logic wr_hit, rd_hit;
    logic wr_ctrl, wr_mask;
    logic rd_clr;
    logic [31:0] wmask;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [NPC_EV_W-1:0] events;

    // Message path; build option and software enable both gate it
    assign msg_en = RX_MSG_IF_EN && ctrl_reg[NPC_CTRL_MSG_EN_BIT];
    assign mi.enable = msg_en;
    assign mi.in_valid = rx_msg_valid;
    assign mi.in_type = rx_msg_type;
    assign mi.in_params = rx_msg_params;
    // Disabled path swallows messages so the decoder never stalls
    assign rx_msg_ready = msg_en ? mi.in_ready : 1'b1;
    assign msg_received = mi.out_strobe;
    assign msg_received_type = mi.out_type;
    assign msg_received_data = mi.out_data;

    npc_msg_ser #(
        .LEN_LUT(MSG_LEN_LUT)
    ) u_ser (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .mi(mi)
    );

    // Two-stage credit pipeline; the lag is what hides the last two cycles
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            nph_s1_reg <= NPC_CRED_NONE;
            npd_s1_reg <= NPC_CRED_NONE;
            nph_reg <= NPC_CRED_NONE;
            npd_reg <= NPC_CRED_NONE;
        end else begin
            nph_s1_reg <= link_up ? npc_cred_enc({4'h0, np_hdr_credits}) : NPC_CRED_NONE;
            npd_s1_reg <= link_up ? npc_cred_enc(np_pld_credits) : NPC_CRED_NONE;
            nph_reg <= link_up ? nph_s1_reg : NPC_CRED_NONE;
            npd_reg <= link_up ? npd_s1_reg : NPC_CRED_NONE;
        end
    end

    assign np_header_credit_avail = nph_reg;
    assign np_payload_credit_avail = npd_reg;

    // Interrupt sources
    always_ff @(posedge ref_clk) begin
        if (!nrst) link_up_d_reg <= 1'b0;
        else link_up_d_reg <= link_up;
    end

    assign events[NPC_EV_MSG_BIT] = mi.done;
    assign events[NPC_EV_NPH_ZERO_BIT] = link_up && (nph_s1_reg == NPC_CRED_NONE)
        && (nph_reg != NPC_CRED_NONE);
    assign events[NPC_EV_NPD_ZERO_BIT] = link_up && (npd_s1_reg == NPC_CRED_NONE)
        && (npd_reg != NPC_CRED_NONE);
    assign events[NPC_EV_LINK_DOWN_BIT] = link_up_d_reg && !link_up;

    // Read of status clears it, but an event in that cycle still lands
    assign rd_clr = rd_take && (s_axi_araddr == NPC_INT_STATUS_OFS);
    assign int_status_next = (rd_clr ? {NPC_EV_W{1'b0}} : int_status_reg) | events;
    assign irq = |(int_status_reg & int_mask_reg);

    // AXI write channel: address and data are caught independently
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
        {8{w_strb_reg[0]}}};
    assign wr_ctrl = (aw_addr_reg == NPC_CTRL_OFS);
    assign wr_mask = (aw_addr_reg == NPC_INT_MASK_OFS);
    // Read-only registers accept a write silently
    assign wr_hit = wr_ctrl || wr_mask || (aw_addr_reg == NPC_STATUS_OFS)
        || (aw_addr_reg == NPC_INT_STATUS_OFS) || (aw_addr_reg == NPC_MSG_COUNT_OFS)
        || (aw_addr_reg == NPC_LAST_MSG_OFS);
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= NPC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? NPC_RESP_OKAY : NPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Writable registers; only bit 0 of control has meaning
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_reg <= NPC_CTRL_RST;
            int_mask_reg <= NPC_INT_MASK_RST;
        end else if (do_write && wr_ctrl) begin
            ctrl_reg <= ((ctrl_reg & ~wmask) | (w_data_reg & wmask)) & NPC_CTRL_RST;
        end else if (do_write && wr_mask) begin
            int_mask_reg <= (int_mask_reg & ~wmask[NPC_EV_W-1:0])
                | (w_data_reg[NPC_EV_W-1:0] & wmask[NPC_EV_W-1:0]);
        end
    end

    // Block state seen by software
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            int_status_reg <= {NPC_EV_W{1'b0}};
            msg_count_reg <= NPC_MSG_COUNT_RST;
            last_type_reg <= 5'h00;
        end else begin
            int_status_reg <= int_status_next;
            if (mi.done) begin
                msg_count_reg <= msg_count_reg + 16'h0001;
                last_type_reg <= mi.out_type;
            end
        end
    end

    // AXI read channel: one outstanding read, answer one cycle after address
    assign s_axi_arready = !rvalid_reg;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign status_word = {26'h00_0000, mi.busy, link_up, npd_reg, nph_reg};

    always_comb begin
        rd_hit = 1'b1;
        if (s_axi_araddr == NPC_CTRL_OFS) begin
            rd_mux = ctrl_reg;
        end else if (s_axi_araddr == NPC_STATUS_OFS) begin
            rd_mux = status_word;
        end else if (s_axi_araddr == NPC_INT_STATUS_OFS) begin
            rd_mux = {28'h000_0000, int_status_reg};
        end else if (s_axi_araddr == NPC_INT_MASK_OFS) begin
            rd_mux = {28'h000_0000, int_mask_reg};
        end else if (s_axi_araddr == NPC_MSG_COUNT_OFS) begin
            rd_mux = {16'h0000, msg_count_reg};
        end else if (s_axi_araddr == NPC_LAST_MSG_OFS) begin
            rd_mux = {27'h00_0000, last_type_reg};
        end else begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= NPC_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? NPC_RESP_OKAY : NPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    property p_nph_code;
        @(posedge ref_clk) disable iff (!nrst)
        $past(nrst, 2) && link_up && $past(link_up) && $past(link_up, 2)
            |-> nph_reg == npc_cred_enc({4'h0, $past(np_hdr_credits, 2)});
    endproperty
    a_nph_code: assert property (p_nph_code) else $error("header code wrong");

    property p_npd_code;
        @(posedge ref_clk) disable iff (!nrst)
        $past(nrst, 2) && link_up && $past(link_up) && $past(link_up, 2)
            |-> npd_reg == npc_cred_enc($past(np_pld_credits, 2));
    endproperty
    a_npd_code: assert property (p_npd_code) else $error("payload code wrong");

    property p_nph_lag;
        @(posedge ref_clk) disable iff (!nrst)
        link_up && $past(link_up) && (np_hdr_credits == 8'h00)
            ##1 link_up && (np_hdr_credits == 8'h00)
            ##1 link_up |-> np_header_credit_avail == NPC_CRED_NONE;
    endproperty
    a_nph_lag: assert property (p_nph_lag) else $error("header lag over two");

    property p_npd_lag;
        @(posedge ref_clk) disable iff (!nrst)
        link_up && (np_pld_credits >= NPC_CRED_SAT) ##1 link_up ##1 link_up
            |-> np_payload_credit_avail == NPC_CRED_MANY;
    endproperty
    a_npd_lag: assert property (p_npd_lag) else $error("payload lag over two");

    property p_down;
        @(posedge ref_clk) disable iff (!nrst)
        !link_up |=> (nph_reg == NPC_CRED_NONE) && (npd_reg == NPC_CRED_NONE);
    endproperty
    a_down: assert property (p_down) else $error("credit shown while link down");

    property p_irq;
        @(posedge ref_clk) disable iff (!nrst)
        mi.done && int_mask_reg[NPC_EV_MSG_BIT] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("message event did not interrupt");
endmodule : npc_status
`default_nettype wire

// ===== npc_user_model.sv
`default_nettype none
module npc_user_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic msg_received,
    input wire logic [4:0] msg_received_type,
    input wire logic [7:0] msg_received_data,
    input wire logic [1:0] np_header_credit_avail,
    input wire logic [1:0] np_payload_credit_avail,
    input wire logic issue_np,
    output logic may_issue,
    output logic [4:0] got_type,
    output logic [31:0] got_bytes,
    output logic [7:0] got_gap
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] sent_reg;
    logic [1:0] nbytes_reg;
    logic [7:0] gap_reg;
    logic strobe_d_reg;
    wire logic [1:0] own_used;

    // Indicators lag our own last two requests, so take those off first
    assign own_used = {1'b0, sent_reg[0]} + {1'b0, sent_reg[1]};
    assign may_issue = (np_header_credit_avail > own_used)
        && (np_payload_credit_avail > own_used);

    // Bytes gathered low first; gap counts idle strobe cycles before a message
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sent_reg <= 2'h0;
            nbytes_reg <= 2'h0;
            gap_reg <= 8'h0;
            strobe_d_reg <= 1'b0;
            got_type <= 5'h0;
            got_bytes <= 32'h0;
            got_gap <= 8'h0;
        end else begin
            sent_reg <= {sent_reg[0], issue_np};
            strobe_d_reg <= msg_received;
            if (!msg_received) begin
                gap_reg <= (gap_reg == 8'hff) ? gap_reg : gap_reg + 8'h1;
            end else if (!strobe_d_reg) begin
                gap_reg <= 8'h0;
                got_gap <= gap_reg;
                got_type <= msg_received_type;
                got_bytes <= {24'h0, msg_received_data};
                nbytes_reg <= 2'h1;
            end else begin
                got_bytes <= got_bytes | ({24'h0, msg_received_data} << (8 * nbytes_reg));
                nbytes_reg <= nbytes_reg + 2'h1;
            end
        end
    end
endmodule : npc_user_model
`default_nettype wire
